//--- hdl/dbg_chan_map.svh
// Offsets, field positions and reset values for the
// debug channel and watch logic.
// Assumes inclusion by bare name from the package.
`ifndef DBG_CHAN_MAP_SVH
`define DBG_CHAN_MAP_SVH

// ----------------------------------------------------------------
// Coprocessor register numbers
// ----------------------------------------------------------------
`define CP_SEL_STATUS 2'h0
`define CP_SEL_DATA 2'h1
`define CP_SEL_DSTAT 2'h2

// ----------------------------------------------------------------
// Scan-side register addresses
// ----------------------------------------------------------------
`define SCAN_CHAN_STATUS 5'h04
`define SCAN_CHAN_DATA 5'h05
`define SCAN_UNIT_FIELD_W 3
`define UNIT_F_ADDR_VAL 3'h0
`define UNIT_F_ADDR_MSK 3'h1
`define UNIT_F_DATA_VAL 3'h2
`define UNIT_F_DATA_MSK 3'h3
`define UNIT_F_CTRL_VAL 3'h4
`define UNIT_F_CTRL_MSK 3'h5
`define UNIT_F_MODE 3'h6

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CHAN_VER_HI 31
`define CHAN_VER_LO 28
`define CHAN_OUT_FULL_BIT 1
`define CHAN_IN_FULL_BIT 0
`define DSTAT_ACK_BIT 0
`define DSTAT_COMPACT_BIT 4
`define DSTAT_RT_BIT 8
`define WORD_RESET 32'h0000_0000
`define CTRL_W 8

`endif

//--- hdl/dbg_chan_pkg.sv
// Types shared by the debug channel and watch logic.
// Assumes the constant header sits beside it in hdl/.
package dbg_chan_pkg;
`include "dbg_chan_map.svh"

    // Coprocessor transfer request from the core pipeline
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] sel;
        logic [31:0] wdata;
    } cp_req_t;

    // Values the core presents on its buses this cycle
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [`CTRL_W-1:0] ctrl;
        logic fetch;
        logic data_acc;
    } core_bus_t;

    // One comparator unit; kind 1 watches fetches, 0 data accesses
    typedef struct packed {
        logic [31:0] addr_val;
        logic [31:0] addr_msk;
        logic [31:0] data_val;
        logic [31:0] data_msk;
        logic [`CTRL_W-1:0] ctrl_val;
        logic [`CTRL_W-1:0] ctrl_msk;
        logic kind;
        logic enable;
    } watch_unit_t;

endpackage : dbg_chan_pkg

//--- hdl/debug_comm_watch.sv
// Debug communication channel, two comparator units and halt gating.
// Assumes core-side signals are synchronous to ref_clk and the debugger
// scan logic runs on scan_clk; external debug pins are asynchronous.
`timescale 1ns/10ps

module debug_comm_watch
    import dbg_chan_pkg::*;
#(
    parameter logic [3:0] VERSION_CODE = 4'h3 // Arbitrary value
) (
    input logic ref_clk,
    input logic nrst,
    input logic ce,
    input logic scan_clk,
    input logic debug_permit_input,
    input logic external_break_hit_input,
    input logic external_watch_hit_input,
    input logic external_halt_request,
    input core_bus_t core_bus,
    input logic core_halted,
    input logic core_compact_state,
    input logic irq_in,
    input logic abort_in,
    input cp_req_t cp_req,
    output logic [31:0] cp_rdata,
    output logic break_to_core,
    output logic watch_to_core,
    output logic halt_req_to_core,
    output logic halted_acknowledge,
    output logic mem_idle,
    output logic irq_to_core,
    output logic abort_to_core,
    input logic host_wr,
    input logic host_rd,
    input logic [4:0] host_addr,
    input logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    output logic host_ready
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Masked equality: a set mask bit removes that bit from the compare
    function automatic logic masked_eq(input logic [31:0] val, input logic [31:0] msk,
                                       input logic [31:0] bus);
        masked_eq = ((val ^ bus) & ~msk) == 32'h0000_0000;
    endfunction : masked_eq

    // ----------------------------------------------------------------
    // Scan-clock side: write launch and reads
    // ----------------------------------------------------------------
    logic [4:0] hold_addr;
    logic [31:0] hold_data;
    logic wr_tog;
    logic rd_tog;
    logic ack_s1;
    logic ack_s2;
    logic [1:0] flag_s1;
    logic [1:0] flag_s2;
    logic next_wr_tog;
    logic wr_busy;
    logic wr_take;
    logic wr_ack_tog;
    logic in_full;
    logic out_full;
    logic [31:0] out_data;

    assign wr_busy = wr_tog != ack_s2;
    assign wr_take = host_wr && !wr_busy;
    assign next_wr_tog = wr_take ? !wr_tog : wr_tog;

    // Acknowledge toggle and channel flags come back over two flops each
    always_ff @(posedge scan_clk or negedge nrst) begin
        if (!nrst) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            flag_s1 <= 2'h0;
            flag_s2 <= 2'h0;
        end else begin
            ack_s1 <= wr_ack_tog;
            ack_s2 <= ack_s1;
            flag_s1 <= {out_full, in_full};
            flag_s2 <= flag_s1;
        end
    end

    // One word in flight; held stable until the core domain acknowledges
    always_ff @(posedge scan_clk or negedge nrst) begin
        if (!nrst) begin
            hold_addr <= 5'h00;
            hold_data <= `WORD_RESET;
            wr_tog <= 1'b0;
            host_ready <= 1'b1;
        end else begin
            if (wr_take) begin
                hold_addr <= host_addr;
                hold_data <= host_wdata;
            end
            wr_tog <= next_wr_tog;
            host_ready <= next_wr_tog == ack_s2;
        end
    end

    // Outbound word is stable while its full flag is set, so it may be
    // read here directly; a read taken with the flag clear returns the last word again
    always_ff @(posedge scan_clk or negedge nrst) begin
        if (!nrst) begin
            host_rdata <= `WORD_RESET;
            rd_tog <= 1'b0;
        end else if (host_rd) begin
            unique case (host_addr)
                `SCAN_CHAN_STATUS: host_rdata <= {VERSION_CODE, 26'h000_0000, flag_s2};
                `SCAN_CHAN_DATA: begin
                    host_rdata <= out_data;
                    rd_tog <= !rd_tog;
                end
                default: host_rdata <= `WORD_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Core-clock side: synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic wr_s1;
    logic wr_s2;
    logic rd_s1;
    logic rd_s2;
    logic rd_s3;
    logic wr_evt;
    logic rd_evt;
    logic permit_s;

    // Pins and scan toggles all pass two flops before use
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            wr_s1 <= 1'b0;
            wr_s2 <= 1'b0;
            wr_ack_tog <= 1'b0;
            rd_s1 <= 1'b0;
            rd_s2 <= 1'b0;
            rd_s3 <= 1'b0;
        end else if (ce) begin
            pin_s1 <= {debug_permit_input, external_halt_request,
                       external_watch_hit_input, external_break_hit_input};
            pin_s2 <= pin_s1;
            wr_s1 <= wr_tog;
            wr_s2 <= wr_s1;
            wr_ack_tog <= wr_s2;
            rd_s1 <= rd_tog;
            rd_s2 <= rd_s1;
            rd_s3 <= rd_s2;
        end
    end

    assign permit_s = pin_s2[3];
    assign wr_evt = ce && (wr_s2 != wr_ack_tog);
    assign rd_evt = ce && (rd_s2 != rd_s3);

    // ----------------------------------------------------------------
    // Comparator units
    // ----------------------------------------------------------------
    watch_unit_t unit [2];
    logic [1:0] unit_hit;
    logic [1:0] unit_brk;

    // Debugger writes land one field at a time
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int u = 0; u < 2; u++) begin
                unit[u] <= '0;
            end
        end else if (wr_evt) begin
            for (int u = 0; u < 2; u++) begin
                if (hold_addr[4:3] == 2'(u + 1)) begin
                    unique case (hold_addr[2:0])
                        `UNIT_F_ADDR_VAL: unit[u].addr_val <= hold_data;
                        `UNIT_F_ADDR_MSK: unit[u].addr_msk <= hold_data;
                        `UNIT_F_DATA_VAL: unit[u].data_val <= hold_data;
                        `UNIT_F_DATA_MSK: unit[u].data_msk <= hold_data;
                        `UNIT_F_CTRL_VAL: unit[u].ctrl_val <= hold_data[`CTRL_W-1:0];
                        `UNIT_F_CTRL_MSK: unit[u].ctrl_msk <= hold_data[`CTRL_W-1:0];
                        `UNIT_F_MODE: {unit[u].kind, unit[u].enable} <= hold_data[1:0];
                        default: unit[u].enable <= unit[u].enable;
                    endcase
                end
            end
        end
    end

    // Hit needs address, data and control all equal outside the masks
    always_comb begin
        for (int u = 0; u < 2; u++) begin
            unit_brk[u] = unit[u].kind;
            unit_hit[u] = unit[u].enable
                && (unit[u].kind ? core_bus.fetch : core_bus.data_acc)
                && masked_eq(unit[u].addr_val, unit[u].addr_msk, core_bus.addr)
                && masked_eq(unit[u].data_val, unit[u].data_msk, core_bus.data)
                && masked_eq({24'h00_0000, unit[u].ctrl_val},
                             {24'hFF_FFFF, unit[u].ctrl_msk},
                             {24'h00_0000, core_bus.ctrl});
        end
    end

    // ----------------------------------------------------------------
    // Core control outputs
    // ----------------------------------------------------------------
    // Permit gates every halt source; registered to keep outputs clean
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            break_to_core <= 1'b0;
            watch_to_core <= 1'b0;
            halt_req_to_core <= 1'b0;
            halted_acknowledge <= 1'b0;
        end else if (ce) begin
            break_to_core <= permit_s && (pin_s2[0] || |(unit_hit & unit_brk));
            watch_to_core <= permit_s && (pin_s2[1] || |(unit_hit & ~unit_brk));
            halt_req_to_core <= permit_s && pin_s2[2];
            halted_acknowledge <= permit_s && core_halted;
        end
    end

    // Halted core stays invisible to the system; bus reset is left to it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem_idle <= 1'b0;
            irq_to_core <= 1'b0;
            abort_to_core <= 1'b0;
        end else if (ce) begin
            mem_idle <= core_halted;
            irq_to_core <= irq_in && !core_halted;
            abort_to_core <= abort_in && !core_halted;
        end
    end

    // ----------------------------------------------------------------
    // Debug status
    // ----------------------------------------------------------------
    logic halted_d;
    logic entry_compact;
    logic rt_bit;
    logic [31:0] dstat;

    // Entry state is caught on the rising edge of the halt
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            halted_d <= 1'b0;
            entry_compact <= 1'b0;
            rt_bit <= 1'b0;
        end else if (ce) begin
            halted_d <= core_halted;
            if (core_halted && !halted_d) begin
                entry_compact <= core_compact_state;
            end
            if (cp_req.valid && cp_req.write && cp_req.sel == `CP_SEL_DSTAT) begin
                rt_bit <= cp_req.wdata[`DSTAT_RT_BIT];
            end
        end
    end

    always_comb begin
        dstat = `WORD_RESET;
        dstat[`DSTAT_ACK_BIT] = halted_acknowledge;
        dstat[`DSTAT_COMPACT_BIT] = entry_compact;
        dstat[`DSTAT_RT_BIT] = rt_bit;
    end

    // ----------------------------------------------------------------
    // Channel registers and flags
    // ----------------------------------------------------------------
    logic [31:0] in_data;
    logic in_set;
    logic in_clr;
    logic out_set;

    assign in_set = wr_evt && hold_addr == `SCAN_CHAN_DATA;
    assign in_clr = ce && cp_req.valid && !cp_req.write && cp_req.sel == `CP_SEL_DATA;
    assign out_set = ce && cp_req.valid && cp_req.write && cp_req.sel == `CP_SEL_DATA;

    // Set beats clear so a word landing with a collect is never lost
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            in_full <= 1'b0;
            in_data <= `WORD_RESET;
        end else if (in_set) begin
            in_full <= 1'b1;
            in_data <= hold_data;
        end else if (in_clr) begin
            in_full <= 1'b0;
        end
    end

    // Outbound is overwritten if software ignores the full flag
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_full <= 1'b0;
            out_data <= `WORD_RESET;
        end else if (out_set) begin
            out_full <= 1'b1;
            out_data <= cp_req.wdata;
        end else if (rd_evt) begin
            out_full <= 1'b0;
        end
    end

    // Coprocessor reads answer one cycle after the request
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cp_rdata <= `WORD_RESET;
        end else if (ce && cp_req.valid && !cp_req.write) begin
            unique case (cp_req.sel)
                `CP_SEL_STATUS: cp_rdata <= {VERSION_CODE, 26'h000_0000, out_full, in_full};
                `CP_SEL_DATA: cp_rdata <= in_data;
                `CP_SEL_DSTAT: cp_rdata <= dstat;
                default: cp_rdata <= `WORD_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_permit_gate;
        ce && !permit_s |=> !halted_acknowledge && !break_to_core && !halt_req_to_core;
    endproperty
    a_permit_gate: assert property (p_permit_gate)
        else $error("halt source passed while permit low");

    property p_in_set;
        in_set |=> in_full && in_data == $past(hold_data);
    endproperty
    a_in_set: assert property (p_in_set)
        else $error("inbound write did not set full");

    property p_in_clr;
        in_clr && !in_set |=> !in_full;
    endproperty
    a_in_clr: assert property (p_in_clr)
        else $error("inbound collect did not clear full");

    property p_out_set;
        out_set |=> out_full && out_data == $past(cp_req.wdata);
    endproperty
    a_out_set: assert property (p_out_set)
        else $error("outbound write did not set full");

    property p_out_clr;
        rd_evt && !out_set |=> !out_full;
    endproperty
    a_out_clr: assert property (p_out_clr)
        else $error("debugger read did not clear outbound full");

    property p_entry_state;
        ce && $rose(core_halted) |=> entry_compact == $past(core_compact_state);
    endproperty
    a_entry_state: assert property (p_entry_state)
        else $error("entry state not recorded");

    property p_halted_quiet;
        ce && core_halted |=> mem_idle && !irq_to_core && !abort_to_core;
    endproperty
    a_halted_quiet: assert property (p_halted_quiet)
        else $error("halted core saw bus or exception activity");

    property p_unit_break;
        ce && permit_s && unit_hit[0] && unit_brk[0] |=> break_to_core;
    endproperty
    a_unit_break: assert property (p_unit_break)
        else $error("comparator hit did not raise break");

    property p_status_read;
        ce && cp_req.valid && !cp_req.write && cp_req.sel == `CP_SEL_STATUS
            |=> cp_rdata[31:28] == VERSION_CODE && cp_rdata[27:2] == 26'h000_0000;
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status version or reserved bits wrong");

endmodule : debug_comm_watch

//--- testbench/host_dbg_model.sv
// Host debugger model driving the scan side of the debug channel.
// Assumes scan_clk comes from the bench and the device answers on it.
`timescale 1ns/10ps
module host_dbg_model
    import dbg_chan_pkg::*;
(
    input wire logic scan_clk,
    input wire logic host_ready,
    input wire logic [31:0] host_rdata,
    output logic host_wr,
    output logic host_rd,
    output logic [4:0] host_addr,
    output logic [31:0] host_wdata
);
    // ----------------------------------------------------------------
    // Scan transfers
    // ----------------------------------------------------------------
    // Released lines show the inverse of the last value, not a stale copy
    initial begin
        host_wr = 1'h0;
        host_rd = 1'h0;
        host_addr = 5'h1f;
        host_wdata = 32'h0000_0000;
    end

    // One register write, raised only once the device can take it
    task automatic scan_wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge scan_clk);
        while (host_ready !== 1'h1 && n < 100) begin
            n++;
            @(posedge scan_clk);
        end
        #1;
        host_wr = 1'h1;
        host_addr = a;
        host_wdata = d;
        @(posedge scan_clk);
        #1;
        host_wr = 1'h0;
        host_addr = ~a;
        host_wdata = ~d;
    endtask : scan_wr

    // One register read; the answer stands until the next read
    task automatic scan_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge scan_clk);
        #1;
        host_rd = 1'h1;
        host_addr = a;
        @(posedge scan_clk);
        #1;
        host_rd = 1'h0;
        host_addr = ~a;
        @(posedge scan_clk);
        #1;
        d = host_rdata;
    endtask : scan_rd

    // Deliver a word only after the processor collected the last one
    task automatic send_word(input logic [31:0] d);
        logic [31:0] s;
        int n;
        n = 0;
        scan_rd(5'h04, s);
        while (s[0] !== 1'h0 && n < 50) begin
            n++;
            scan_rd(5'h04, s);
        end
        scan_wr(5'h05, d);
    endtask : send_word

    // Scan out a word once the processor flags one waiting
    task automatic take_word(output logic [31:0] d);
        logic [31:0] s;
        int n;
        n = 0;
        scan_rd(5'h04, s);
        while (s[1] !== 1'h1 && n < 50) begin
            n++;
            scan_rd(5'h04, s);
        end
        scan_rd(5'h05, d);
    endtask : take_word
endmodule : host_dbg_model

//--- testbench/tb_debug_comm_watch.sv
// Self-checking bench for the debug channel, comparators and halt gating.
// Assumes the host model above; ce is tied high throughout.
`timescale 1ns/10ps
module tb_debug_comm_watch
    import dbg_chan_pkg::*;
;
    // ----------------------------------------------------------------
    // Stimulus and wiring
    // ----------------------------------------------------------------
    localparam logic [3:0] VER = 4'h3; // Arbitrary version value
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic fetch;
        logic acc;
        logic [1:0] hit;
    } row_t;
    // Unit0 fetch breakpoint at 0x1000 (low nibble masked), unit1 data watch
    localparam logic [31:0] CFG [14] = '{32'h0000_1000, 32'h0000_000f, 32'h0000_0000,
        32'hffff_ffff, 32'h0000_0000, 32'h0000_00ff, 32'h0000_0003, 32'h0000_2000,
        32'h0000_0000, 32'h0000_00ab, 32'hffff_ff00, 32'h0000_0000, 32'h0000_00ff,
        32'h0000_0001};
    localparam row_t ROWS [6] = '{
        '{32'h0000_1003, 32'h0000_0000, 1'h1, 1'h0, 2'h2},
        '{32'h0000_1013, 32'h0000_0000, 1'h1, 1'h0, 2'h0},
        '{32'h0000_1000, 32'h0000_0000, 1'h0, 1'h1, 2'h0},
        '{32'h0000_2000, 32'h0000_12ab, 1'h0, 1'h1, 2'h1},
        '{32'h0000_2000, 32'h0000_12ac, 1'h0, 1'h1, 2'h0},
        '{32'h0000_2004, 32'h0000_00ab, 1'h0, 1'h1, 2'h0}};
    logic ref_clk = 1'h0, scan_clk = 1'h0, nrst = 1'h0;
    logic debug_permit_input = 1'h1, core_halted = 1'h0, core_compact_state = 1'h0;
    logic external_break_hit_input = 1'h0, external_watch_hit_input = 1'h0;
    logic external_halt_request = 1'h0, irq_in = 1'h0, abort_in = 1'h0;
    core_bus_t core_bus = '0;
    cp_req_t cp_req = '0;
    logic [31:0] cp_rdata, host_rdata, host_wdata, rd;
    logic break_to_core, watch_to_core, halt_req_to_core, halted_acknowledge;
    logic mem_idle, irq_to_core, abort_to_core, host_wr, host_rd, host_ready;
    logic [4:0] host_addr;
    int bad_count = 0, checks = 0, cycles = 0;

    debug_comm_watch #(.VERSION_CODE(VER)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
        .ce(1'h1), .scan_clk(scan_clk), .debug_permit_input(debug_permit_input),
        .external_break_hit_input(external_break_hit_input),
        .external_watch_hit_input(external_watch_hit_input),
        .external_halt_request(external_halt_request), .core_bus(core_bus),
        .core_halted(core_halted), .core_compact_state(core_compact_state),
        .irq_in(irq_in), .abort_in(abort_in), .cp_req(cp_req), .cp_rdata(cp_rdata),
        .break_to_core(break_to_core), .watch_to_core(watch_to_core),
        .halt_req_to_core(halt_req_to_core), .halted_acknowledge(halted_acknowledge),
        .mem_idle(mem_idle), .irq_to_core(irq_to_core), .abort_to_core(abort_to_core),
        .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ready(host_ready));
    host_dbg_model host_u (.scan_clk(scan_clk), .host_ready(host_ready),
        .host_rdata(host_rdata), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata));

    // Two unrelated clocks; the scan clock keeps running so flags can sync back
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #17;
        forever #62.5 scan_clk = ~scan_clk;
    end
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h wanted %h", $time, m, seen, exp);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : idle
    // Coprocessor transfer: one-cycle request, answer read once it stands
    task automatic cp(input logic w, input logic [1:0] s, input logic [31:0] wd,
            output logic [31:0] r);
        @(negedge ref_clk);
        cp_req = '{1'h1, w, s, wd};
        @(negedge ref_clk);
        cp_req.valid = 1'h0;
        @(negedge ref_clk);
        r = cp_rdata;
    endtask : cp
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        idle(8);
        nrst = 1'h1;
        idle(2);
        check({31'h0, host_ready}, 32'h0000_0001, "ready after reset");
        cp(1'h0, 2'h0, 32'h0000_0000, rd);
        check(rd, {VER, 28'h000_0000}, "status after reset");
        // Comparator rows, units programmed over the scan side
        for (int i = 0; i < 14; i++) begin
            host_u.scan_wr(i < 7 ? 5'(8 + i) : 5'(9 + i), CFG[i]);
        end
        idle(40);
        for (int i = 0; i < 6; i++) begin
            core_bus = '{ROWS[i].addr, ROWS[i].data, 8'h00, ROWS[i].fetch, ROWS[i].acc};
            idle(2);
            check({30'h0, break_to_core, watch_to_core}, 32'(ROWS[i].hit), "hit");
        end
        core_bus = '0;
        // Inbound word: flag set by the debugger, cleared by the core read
        host_u.send_word(32'h1234_5678);
        idle(10);
        cp(1'h0, 2'h0, 32'h0000_0000, rd);
        check(rd, {VER, 28'h000_0001}, "inbound full");
        cp(1'h0, 2'h1, 32'h0000_0000, rd);
        check(rd, 32'h1234_5678, "inbound word");
        cp(1'h0, 2'h0, 32'h0000_0000, rd);
        check(rd, {VER, 28'h000_0000}, "inbound taken");
        // Outbound word; a write to the status number must change nothing
        cp(1'h1, 2'h1, 32'hcafe_0001, rd);
        cp(1'h1, 2'h0, 32'hffff_ffff, rd);
        cp(1'h0, 2'h0, 32'h0000_0000, rd);
        check(rd, {VER, 28'h000_0002}, "outbound full");
        host_u.take_word(rd);
        check(rd, 32'hcafe_0001, "outbound word");
        idle(10);
        cp(1'h0, 2'h0, 32'h0000_0000, rd);
        check(rd, {VER, 28'h000_0000}, "outbound taken");
        host_u.scan_rd(5'h1f, rd);
        check(rd, 32'h0000_0000, "unmapped scan read");
        // The single core-writable debug status bit
        for (int k = 0; k < 2; k++) begin
            cp(1'h1, 2'h2, {32{k[0]}}, rd);
            cp(1'h0, 2'h2, 32'h0000_0000, rd);
            check({31'h0, rd[8]}, 32'(k), "core status bit");
        end
        // Halt entry from each instruction state
        irq_in = 1'h1;
        abort_in = 1'h1;
        for (int k = 0; k < 2; k++) begin
            core_compact_state = k[0];
            core_halted = 1'h1;
            idle(4);
            check({29'h0, halted_acknowledge, mem_idle, irq_to_core | abort_to_core},
                32'h6, "halted");
            cp(1'h0, 2'h2, 32'h0000_0000, rd);
            check({31'h0, rd[4]}, 32'(k), "entry state");
            core_halted = 1'h0;
            idle(4);
            check({29'h0, mem_idle, irq_to_core, abort_to_core}, 32'h3, "running");
        end
        // External pins pass when permitted, blocked when not
        external_break_hit_input = 1'h1;
        external_watch_hit_input = 1'h1;
        external_halt_request = 1'h1;
        idle(5);
        check({29'h0, halt_req_to_core, break_to_core, watch_to_core}, 32'h7, "pins");
        debug_permit_input = 1'h0;
        core_halted = 1'h1;
        idle(6);
        check({28'h0, halt_req_to_core, break_to_core, watch_to_core,
            halted_acknowledge}, 32'h0, "pins blocked");
        // Reset in mid-run with a word waiting
        cp(1'h1, 2'h1, 32'h0000_00a5, rd);
        // Leave debug state first: bus reset must not move while halted
        core_halted = 1'h0;
        idle(2);
        nrst = 1'h0;
        idle(8);
        nrst = 1'h1;
        idle(2);
        cp(1'h0, 2'h0, 32'h0000_0000, rd);
        check(rd, {VER, 28'h000_0000}, "status after second reset");
        conclude();
    end
endmodule : tb_debug_comm_watch
